// File: hw/dee_pkg.sv
// dee_pkg: constants shared by both ends of the data eeprom erase/program control
// assumes a 125 MHz core clock and 16-bit register writes from the core side
package dee_pkg;
    localparam int          CLK_MHZ        = 125;
    localparam int          CYCLE_US       = 2000;
    localparam int          CYCLE_CLKS     = CYCLE_US * CLK_MHZ;
    localparam int          PWRUP_US       = 64;
    localparam int          PWRUP_CLKS     = PWRUP_US * CLK_MHZ;
    localparam logic [15:0] OFS_OP_CONTROL = 16'h0760;
    localparam logic [15:0] OFS_ADDR_LOW   = 16'h0762;
    localparam logic [15:0] OFS_ADDR_HIGH  = 16'h0764;
    localparam logic [15:0] OFS_UNLOCK_KEY = 16'h0766;
    localparam int          BIT_GO         = 15;
    localparam int          BIT_PERMIT     = 14;
    localparam int          BIT_ABORT_ERR  = 13;
    localparam int          BIT_ERASE      = 6;
    localparam logic [5:0]  OP_WORD_ERASE  = 6'h04;
    localparam logic [5:0]  OP_WORD_PROG   = 6'h04;
    localparam logic [5:0]  OP_BLOCK_PROG  = 6'h0A;
    localparam logic [5:0]  OP_BLOCK_ERASE = 6'h05;
    localparam logic [15:0] CMD_WORD_ERASE = 16'h4044;
    localparam logic [15:0] CMD_WORD_PROG  = 16'h4004;
    localparam logic [15:0] CMD_BLOCK_PROG = 16'h400A;
    localparam logic [7:0]  KEY_FIRST      = 8'h55;
    localparam logic [7:0]  KEY_SECOND     = 8'hAA;
    localparam logic [23:0] EE_BASE        = 24'h7FF000;
    localparam logic [23:0] EE_LAST        = 24'h7FFFFE;
    localparam int          LATCHES        = 16;
    localparam logic [15:0] CTRL_RESET     = 16'h0000;
    typedef enum logic [1:0] {OPK_WORD_ERASE, OPK_WORD_PROG, OPK_BLOCK_PROG} dee_op_t;
    // true when a byte address falls inside the data eeprom window
    function automatic logic dee_in_window(input logic [23:0] a);
        return (a >= EE_BASE) && (a <= EE_LAST);
    endfunction
endpackage

// File: hw/dee_if.sv
// dee_if: core register/table-write port joining the core end and the eeprom controller
// assumes both ends run on the same clock and reset
`timescale 1ns/100ps
interface dee_if;
    logic        reg_wr;
    logic        reg_rd;
    logic [15:0] reg_addr;
    logic [15:0] reg_wdata;
    logic [15:0] reg_rdata;
    logic        tbl_wr;
    logic [23:0] tbl_addr;
    logic [15:0] tbl_wdata;
    logic        done_flag;
    logic        done_clr;
    logic        busy;
    modport ctrl (input reg_wr, reg_rd, reg_addr, reg_wdata, tbl_wr, tbl_addr, tbl_wdata,
                  done_clr, output reg_rdata, done_flag, busy);
    modport core (output reg_wr, reg_rd, reg_addr, reg_wdata, tbl_wr, tbl_addr, tbl_wdata,
                  done_clr, input reg_rdata, done_flag, busy);
endinterface

// File: hw/dee_ctrl.sv
// dee_ctrl: data eeprom erase/program controller (device end)
// assumes core writes arrive on ref_clk_in; cell array model is outside this block
// What this block does
// - go with erase selected starts erase
// - core loads address before erase
// - 0x4044 selects single word erase
// - 0x4004 selects single word program
// - 0x400A selects sixteen word block program
// - keys 55 then AA then go
// - go refused unless permit already set
// - permit and go same write refused
// - hardware clears permit only at reset or power-up
// - clearing permit never aborts running cycle
// - end clears go, sets done flag
// - core clears done flag itself
// - erase takes 2 ms, core runs on
// - program takes 2 ms, core runs on
// - table write updates address registers
// - core erases before programming word; dee_core does not, t_word_prog requests the erase first
// - core loads sixteen latches first
// - power-up clears permit, blocks writes
// - core keeps permit clear normally
// - core may verify written data
// - reset during cycle flags abort error
// - reads during cycle return unspecified data
// - eeprom spans 0x7FF000 to 0x7FFFFE
`timescale 1ns/100ps
module dee_ctrl
    import dee_pkg::*;
#(
    parameter int CYCLE_CNT = CYCLE_CLKS,
    parameter int PWRUP_CNT = PWRUP_CLKS
) (
    input  wire logic        ref_clk_in,
    input  wire logic        rstn_in,
    input  wire logic        por_in,
    dee_if.ctrl              bus,
    output logic             cell_start_out,
    output logic [1:0]       cell_op_out,
    output logic [23:0]      cell_addr_out,
    output logic [LATCHES*16-1:0] cell_latch_out,
    output logic             cell_busy_out
);
    typedef enum logic [1:0] {KEY_IDLE, KEY_GOT1, KEY_ARMED} dee_key_t;
    dee_key_t    key_q;
    logic [15:0] ctrl_q;
    logic        abort_err_q;
    logic        run_q;
    logic [7:0]  addr_hi_q;
    logic [15:0] addr_lo_q;
    logic [31:0] cnt_q;
    logic [31:0] pwr_q;
    logic        done_q;
    logic [15:0] latch_q [LATCHES];
    logic        wr_ctrl;
    logic        wr_key;
    logic        wr_addr_lo;
    logic        wr_addr_hi;
    logic        tbl_hit;
    logic        run_seen_q;
    logic        start;
    logic [5:0]  op_sel;

    // register write strobe for one offset
    function automatic logic reg_hit(input logic        wr,
                                     input logic [15:0] a,
                                     input logic [15:0] ofs);
        return wr && (a == ofs);
    endfunction

    assign wr_ctrl    = reg_hit(bus.reg_wr, bus.reg_addr, OFS_OP_CONTROL);
    assign wr_key     = reg_hit(bus.reg_wr, bus.reg_addr, OFS_UNLOCK_KEY);
    assign wr_addr_lo = reg_hit(bus.reg_wr, bus.reg_addr, OFS_ADDR_LOW);
    assign wr_addr_hi = reg_hit(bus.reg_wr, bus.reg_addr, OFS_ADDR_HIGH);
    // table writes outside the window or during a cycle are ignored
    assign tbl_hit    = bus.tbl_wr && dee_in_window(bus.tbl_addr) && !run_q;
    assign op_sel     = ctrl_q[5:0];
    // permit must already stand, keys armed, outside power-up, not running
    assign start = wr_ctrl && bus.reg_wdata[BIT_GO] && ctrl_q[BIT_PERMIT]
                && (key_q == KEY_ARMED) && !run_q && (pwr_q == 32'd0);

    // unlock tracker
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            key_q <= KEY_IDLE;
        end else if (wr_key) begin
            if (bus.reg_wdata[7:0] == KEY_FIRST)
                key_q <= KEY_GOT1;
            else if (key_q == KEY_GOT1 && bus.reg_wdata[7:0] == KEY_SECOND)
                key_q <= KEY_ARMED;
            else
                key_q <= KEY_IDLE;
        end else if (bus.reg_wr || bus.tbl_wr) begin
            key_q <= KEY_IDLE;
        end
    end

    // control register; permit changes only by software, reset or power-up
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ctrl_q <= CTRL_RESET;
        end else if (por_in) begin
            ctrl_q <= CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl_q[BIT_PERMIT] <= bus.reg_wdata[BIT_PERMIT];
            if (!run_q)
                ctrl_q[6:0] <= bus.reg_wdata[6:0];
        end
    end

    // run state one edge back; no reset, so a reset that cuts a cycle still sees it
    always_ff @(posedge ref_clk_in) begin
        run_seen_q <= run_q;
    end

    // abort error: reset arrives with a cycle running
    always_ff @(posedge ref_clk_in) begin
        if (por_in)
            abort_err_q <= 1'b0;
        else if (!rstn_in && run_seen_q)
            abort_err_q <= 1'b1;
        else if (wr_ctrl && !bus.reg_wdata[BIT_ABORT_ERR])
            abort_err_q <= 1'b0;
    end

    // address capture from table writes; left untouched by reset
    always_ff @(posedge ref_clk_in) begin
        if (tbl_hit) begin
            addr_hi_q <= bus.tbl_addr[23:16];
            addr_lo_q <= bus.tbl_addr[15:0];
        end else if (wr_addr_lo && !run_q) begin
            addr_lo_q <= bus.reg_wdata;
        end else if (wr_addr_hi && !run_q) begin
            addr_hi_q <= bus.reg_wdata[7:0];
        end
    end

    // write latches, indexed by word within the block
    always_ff @(posedge ref_clk_in) begin
        if (tbl_hit)
            latch_q[bus.tbl_addr[4:1]] <= bus.tbl_wdata;
    end

    // cycle timer; permit is not looked at once running
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            run_q <= 1'b0;
            cnt_q <= 32'd0;
        end else if (start) begin
            run_q <= 1'b1;
            cnt_q <= 32'(CYCLE_CNT - 1);
        end else if (run_q) begin
            if (cnt_q == 32'd0)
                run_q <= 1'b0;
            else
                cnt_q <= cnt_q - 32'd1;
        end
    end

    // power-up timer
    // starts stay refused until it has run down
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in)
            pwr_q <= 32'd0;
        else if (por_in)
            pwr_q <= 32'(PWRUP_CNT);
        else if (pwr_q != 32'd0)
            pwr_q <= pwr_q - 32'd1;
    end

    // done flag: set wins over clear
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in)
            done_q <= 1'b0;
        else if (run_q && cnt_q == 32'd0)
            done_q <= 1'b1;
        else if (bus.done_clr)
            done_q <= 1'b0;
    end

    // register read mux; array reads during a cycle are not defined here
    // go is not stored: bit 15 reads back the running cycle
    always_comb begin
        unique case (bus.reg_addr)
            OFS_OP_CONTROL: bus.reg_rdata = {run_q, ctrl_q[BIT_PERMIT], abort_err_q,
                                             6'h00, ctrl_q[6:0]};
            OFS_ADDR_LOW:   bus.reg_rdata = addr_lo_q;
            OFS_ADDR_HIGH:  bus.reg_rdata = {8'h00, addr_hi_q};
            default:        bus.reg_rdata = 16'h0000;
        endcase
    end

    assign bus.done_flag   = done_q;
    assign bus.busy        = run_q;
    assign cell_start_out  = start;
    assign cell_busy_out   = run_q;
    assign cell_addr_out   = {addr_hi_q, addr_lo_q};
    // erase bit alone picks erase; 0x0A picks block program, other codes word program
    assign cell_op_out     = ctrl_q[BIT_ERASE] ? 2'(OPK_WORD_ERASE)
                           : (op_sel == OP_BLOCK_PROG) ? 2'(OPK_BLOCK_PROG)
                           : 2'(OPK_WORD_PROG);
    genvar gi;
    generate
        for (gi = 0; gi < LATCHES; gi++) begin : g_lat
            assign cell_latch_out[gi*16 +: 16] = latch_q[gi];
        end
    endgenerate
endmodule // dee_ctrl

// File: hw/dee_core.sv
// dee_core: core-side sequencer issuing erase/program sequences to the controller
// assumes dee_ctrl on the other modport, same clock
`timescale 1ns/100ps
module dee_core
    import dee_pkg::*;
(
    input  wire logic        ref_clk_in,
    input  wire logic        rstn_in,
    dee_if.core              bus,
    input  wire logic        req_in,
    input  wire logic [1:0]  req_op_in,
    input  wire logic [23:0] req_addr_in,
    input  wire logic [15:0] req_data_in,
    output logic             req_ready_out,
    output logic             req_done_out
);
    typedef enum logic [3:0] {S_IDLE, S_ADL, S_ADH, S_TBL, S_CFG, S_K1, S_K2, S_GO, S_WAIT,
                              S_CLR, S_OFF} dee_cst_t;
    dee_cst_t    st_q;
    logic [1:0]  op_q;
    logic [23:0] addr_q;
    logic [15:0] data_q;
    logic [3:0]  idx_q;
    logic        done_q;

    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            st_q   <= S_IDLE;
            op_q   <= 2'd0;
            addr_q <= 24'h000000;
            data_q <= 16'h0000;
            idx_q  <= 4'h0;
        end else begin
            unique case (st_q)
                S_IDLE: if (req_in) begin
                    op_q   <= req_op_in;
                    addr_q <= req_addr_in;
                    data_q <= req_data_in;
                    idx_q  <= 4'h0;
                    st_q   <= (req_op_in == 2'(OPK_WORD_ERASE)) ? S_ADL : S_TBL;
                end
                S_ADL:  st_q <= S_ADH;
                S_ADH:  st_q <= S_CFG;
                S_TBL: begin
                    idx_q <= idx_q + 4'h1;
                    if (op_q != 2'(OPK_BLOCK_PROG) || idx_q == 4'(LATCHES - 1))
                        st_q <= S_CFG;
                end
                S_CFG:  st_q <= S_K1;
                S_K1:   st_q <= S_K2;
                S_K2:   st_q <= S_GO;
                S_GO:   st_q <= S_WAIT;
                S_WAIT: if (bus.done_flag) st_q <= S_CLR;
                S_CLR:  st_q <= S_OFF;
                S_OFF:  st_q <= S_IDLE;
                default: st_q <= S_IDLE;
            endcase
        end
    end

    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in)
            done_q <= 1'b0;
        else
            done_q <= (st_q == S_OFF);
    end

    logic [15:0] cfg;
    always_comb begin
        unique case (op_q)
            2'(OPK_WORD_ERASE): cfg = CMD_WORD_ERASE;
            2'(OPK_BLOCK_PROG): cfg = CMD_BLOCK_PROG;
            default:            cfg = CMD_WORD_PROG;
        endcase
        bus.reg_wr    = 1'b0;
        bus.reg_rd    = 1'b0;
        bus.reg_addr  = OFS_OP_CONTROL;
        bus.reg_wdata = 16'h0000;
        unique case (st_q)
            S_ADL: begin
                bus.reg_wr    = 1'b1;
                bus.reg_addr  = OFS_ADDR_LOW;
                bus.reg_wdata = addr_q[15:0];
            end
            S_ADH: begin
                bus.reg_wr    = 1'b1;
                bus.reg_addr  = OFS_ADDR_HIGH;
                bus.reg_wdata = {8'h00, addr_q[23:16]};
            end
            S_CFG: begin bus.reg_wr = 1'b1; bus.reg_wdata = cfg; end
            S_K1:  begin bus.reg_wr = 1'b1; bus.reg_addr = OFS_UNLOCK_KEY;
                         bus.reg_wdata = {8'h00, KEY_FIRST}; end
            S_K2:  begin bus.reg_wr = 1'b1; bus.reg_addr = OFS_UNLOCK_KEY;
                         bus.reg_wdata = {8'h00, KEY_SECOND}; end
            S_GO:  begin bus.reg_wr = 1'b1; bus.reg_wdata = cfg | 16'h8000; end
            S_OFF: begin bus.reg_wr = 1'b1; bus.reg_wdata = 16'h0000; end
            default: ;
        endcase
    end

    assign bus.tbl_wr      = (st_q == S_TBL);
    assign bus.tbl_addr    = (op_q == 2'(OPK_BLOCK_PROG))
                           ? {addr_q[23:5], idx_q, 1'b0} : addr_q;
    assign bus.tbl_wdata   = data_q + 16'(idx_q);
    assign bus.done_clr    = (st_q == S_CLR);
    assign req_ready_out   = (st_q == S_IDLE);
    assign req_done_out    = done_q;
endmodule // dee_core

// File: tb/dee_properties.sv
// dee_properties: timing checks on the link between core end and controller
// assumes one clock, active-low async reset and the dee_pkg offsets
`timescale 1ns/100ps
module dee_properties
    import dee_pkg::*;
#(
    parameter int CYCLE_CNT = 20
) (
    input wire logic        ref_clk_in,
    input wire logic        rstn_in,
    input wire logic        reg_wr,
    input wire logic [15:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic        done_flag,
    input wire logic        done_clr,
    input wire logic        busy
);
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rstn_in);
    logic [1:0] key_q;
    logic       perm_q;
    logic       arm_q;
    int         cnt_q;
    wire        ctl_wr = reg_wr && (reg_addr == OFS_OP_CONTROL);
    wire        key_wr = reg_wr && (reg_addr == OFS_UNLOCK_KEY);
    wire        go_ok  = ctl_wr && reg_wdata[BIT_GO] && key_q == 2'h2 && perm_q && !busy;
    // unlock tracker: any register write other than the next key drops it; table writes are not seen
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) key_q <= 2'h0;
        else if (key_wr && reg_wdata[7:0] == KEY_FIRST) key_q <= 2'h1;
        else if (key_wr && reg_wdata[7:0] == KEY_SECOND && key_q == 2'h1) key_q <= 2'h2;
        else if (reg_wr) key_q <= 2'h0;
    end
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) perm_q <= 1'b0;
        else if (ctl_wr) perm_q <= reg_wdata[BIT_PERMIT];
    end
    // counts edges since an accepted start, returns to zero when done is seen
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            arm_q <= 1'b0;
            cnt_q <= 0;
        end else begin
            arm_q <= go_ok;
            if (arm_q) cnt_q <= 1;
            else if (cnt_q != 0 && !done_flag) cnt_q <= cnt_q + 1;
            else cnt_q <= 0;
        end
    end
    sequence start_s;
        arm_q ##1 busy;
    endsequence
    sequence fin_s;
        $rose(done_flag);
    endsequence
    AST_START: assert property (go_ok |=> start_s)
        else $error("accepted start did not raise busy");
    AST_ONLY_ARMED: assert property ($rose(busy) |-> arm_q || $past(arm_q))
        else $error("busy rose without keyed permitted start");
    AST_CYCLE_LEN: assert property (fin_s |-> cnt_q == CYCLE_CNT)
        else $error("cycle length wrong");
    AST_BUSY_HOLDS: assert property (cnt_q != 0 && cnt_q < CYCLE_CNT |-> busy)
        else $error("busy dropped mid cycle");
    AST_END_CLEARS_GO: assert property (fin_s |-> ##[0:1] !busy)
        else $error("busy not cleared at cycle end");
    AST_DONE_CAUSE: assert property (fin_s |-> $past(busy))
        else $error("done without running cycle");
    AST_DONE_STICKY: assert property (done_flag && !done_clr |=> done_flag)
        else $error("done flag cleared by device");
    AST_DONE_CLEAR: assert property (done_clr && !busy |=> !done_flag)
        else $error("done flag not cleared");
endmodule // dee_properties

// File: tb/dee_tb_top.sv
// dee_tb_top: core end against controller, plus a bench-driven second controller
// assumes dee_pkg, dee_if, dee_ctrl, dee_core and dee_properties compiled first
`timescale 1ns/100ps
module dee_tb_top
    import dee_pkg::*;
;
    localparam int N = 20;
    logic        ref_clk_in = 1'b0;
    logic        rstn_in = 1'b0;
    logic        por_in = 1'b0;
    logic        req_in = 1'b0;
    logic [1:0]  req_op_in = 2'h0;
    logic [23:0] req_addr_in = 24'h000000;
    logic [15:0] req_data_in = 16'h0000;
    logic        req_ready_out, req_done_out, start_w;
    logic [1:0]  op_w, seen_op;
    logic [23:0] addr_w;
    logic [LATCHES*16-1:0] lat_w;
    int          bad_count = 0;
    int          checks_done = 0;
    dee_if bus();
    dee_if bad();
    always #4 ref_clk_in = ~ref_clk_in;
    dee_ctrl #(.CYCLE_CNT(N), .PWRUP_CNT(4)) u_dee_ctrl (.ref_clk_in(ref_clk_in),
        .rstn_in(rstn_in), .por_in(por_in), .bus(bus), .cell_start_out(start_w),
        .cell_op_out(op_w), .cell_addr_out(addr_w), .cell_latch_out(lat_w), .cell_busy_out());
    dee_core u_dee_core (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .bus(bus),
        .req_in(req_in), .req_op_in(req_op_in), .req_addr_in(req_addr_in),
        .req_data_in(req_data_in), .req_ready_out(req_ready_out), .req_done_out(req_done_out));
    dee_ctrl #(.CYCLE_CNT(N), .PWRUP_CNT(4)) u_dee_ctrl_bad (.ref_clk_in(ref_clk_in),
        .rstn_in(rstn_in), .por_in(por_in), .bus(bad), .cell_start_out(),
        .cell_op_out(), .cell_addr_out(), .cell_latch_out(), .cell_busy_out());
    dee_properties #(.CYCLE_CNT(N)) u_dee_properties (.ref_clk_in(ref_clk_in),
        .rstn_in(rstn_in), .reg_wr(bus.reg_wr), .reg_addr(bus.reg_addr),
        .reg_wdata(bus.reg_wdata), .done_flag(bus.done_flag), .done_clr(bus.done_clr),
        .busy(bus.busy));
    always @(posedge ref_clk_in) if (start_w === 1'b1) seen_op <= op_w;
    task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // one full sequence through the core end
    task automatic run_req(input logic [1:0] op, input logic [23:0] a);
        int n;
        @(negedge ref_clk_in);
        for (n = 0; n < 50 && req_ready_out !== 1'b1; n++) @(negedge ref_clk_in);
        req_in = 1'b1;
        req_op_in = op;
        req_addr_in = a;
        req_data_in = a[15:0] ^ 16'hA5A5;
        @(negedge ref_clk_in);
        req_in = 1'b0;
        for (n = 0; n < N * 4 + 200 && req_done_out !== 1'b1; n++) @(negedge ref_clk_in);
        check("req done", req_done_out, 1'b1);
        check("cell op", seen_op, op);
    endtask
    task automatic t_word_erase();
        run_req(OPK_WORD_ERASE, 24'h7FF010);
        check("erase addr", addr_w, 24'h7FF010);
    endtask
    task automatic t_word_prog();
        run_req(OPK_WORD_ERASE, EE_LAST);
        run_req(OPK_WORD_PROG, EE_LAST);
        check("prog addr", addr_w, EE_LAST);
        check("prog latch", lat_w[255:240], 16'h5A5B);
    endtask
    task automatic t_block_prog();
        run_req(OPK_BLOCK_PROG, 24'h7FF020);
        check("block addr", addr_w, 24'h7FF03E);
        check("block first latch", lat_w[15:0], 16'h5585);
        check("block last latch", lat_w[255:240], 16'h5594);
    endtask
    task automatic bw(input logic [15:0] a, input logic [15:0] d);
        @(negedge ref_clk_in);
        bad.reg_wr = 1'b1;
        bad.reg_addr = a;
        bad.reg_wdata = d;
        @(negedge ref_clk_in);
        bad.reg_wr = 1'b0;
    endtask
    task automatic keyed(input logic [7:0] k1, input logic [7:0] k2, input logic [15:0] c);
        bw(OFS_UNLOCK_KEY, {8'h00, k1});
        bw(OFS_UNLOCK_KEY, {8'h00, k2});
        bw(OFS_OP_CONTROL, c | 16'h8000);
        @(negedge ref_clk_in);
    endtask
    task automatic t_refused();
        bw(OFS_OP_CONTROL, 16'h0044);
        keyed(KEY_FIRST, KEY_SECOND, CMD_WORD_ERASE);
        check("go with permit", bad.busy, 1'b0);
        bw(OFS_OP_CONTROL, CMD_WORD_ERASE);
        keyed(KEY_SECOND, KEY_FIRST, CMD_WORD_ERASE);
        check("swapped keys", bad.busy, 1'b0);
        bw(OFS_UNLOCK_KEY, {8'h00, KEY_FIRST});
        bw(OFS_ADDR_LOW, 16'h1000);
        bw(OFS_UNLOCK_KEY, {8'h00, KEY_SECOND});
        bw(OFS_OP_CONTROL, CMD_WORD_ERASE | 16'h8000);
        @(negedge ref_clk_in);
        check("split keys", bad.busy, 1'b0);
    endtask
    task automatic t_good_cycle();
        @(negedge ref_clk_in);
        bad.tbl_addr = 24'h7FF01E;
        bad.tbl_wr = 1'b1;
        @(negedge ref_clk_in);
        bad.tbl_wr = 1'b0;
        bad.reg_addr = OFS_ADDR_LOW;
        #1 check("addr low", bad.reg_rdata, 16'hF01E);
        bw(OFS_OP_CONTROL, CMD_WORD_ERASE);
        keyed(KEY_FIRST, KEY_SECOND, CMD_WORD_ERASE);
        check("busy", bad.busy, 1'b1);
        bw(OFS_OP_CONTROL, 16'h0044);
        check("busy kept", bad.busy, 1'b1);
        repeat (N + 4) @(negedge ref_clk_in);
        check("done", {bad.done_flag, bad.busy}, 2'b10);
        bad.reg_addr = OFS_OP_CONTROL;
        #1 check("ctrl go permit", bad.reg_rdata[15:14], 2'b00);
        bw(OFS_OP_CONTROL, CMD_WORD_ERASE);
        check("done kept", bad.done_flag, 1'b1);
        bad.done_clr = 1'b1;
        @(negedge ref_clk_in);
        bad.done_clr = 1'b0;
        bad.reg_addr = OFS_OP_CONTROL;
        #1 check("permit kept", bad.reg_rdata[14], 1'b1);
        check("done cleared", bad.done_flag, 1'b0);
    endtask
    // reset cuts a running cycle, then a power-up pulse
    task automatic t_abort();
        bw(OFS_OP_CONTROL, CMD_WORD_ERASE);
        keyed(KEY_FIRST, KEY_SECOND, CMD_WORD_ERASE);
        check("abort run", bad.busy, 1'b1);
        rstn_in = 1'b0;
        repeat (2) @(negedge ref_clk_in);
        rstn_in = 1'b1;
        @(negedge ref_clk_in);
        bad.reg_addr = OFS_OP_CONTROL;
        #1 check("abort flag", bad.reg_rdata[BIT_ABORT_ERR], 1'b1);
        bad.reg_addr = OFS_ADDR_LOW;
        #1 check("abort addr", bad.reg_rdata, 16'hF01E);
        bw(OFS_OP_CONTROL, CMD_WORD_ERASE);
        por_in = 1'b1;
        @(negedge ref_clk_in);
        por_in = 1'b0;
        bad.reg_addr = OFS_OP_CONTROL;
        #1 check("por permit", bad.reg_rdata[BIT_PERMIT], 1'b0);
    endtask
    initial begin
        bad.reg_wr = 1'b0;
        bad.reg_rd = 1'b0;
        bad.reg_addr = 16'h0000;
        bad.reg_wdata = 16'h0000;
        bad.tbl_wr = 1'b0;
        bad.tbl_addr = 24'h000000;
        bad.tbl_wdata = 16'h5A5A;
        bad.done_clr = 1'b0;
        repeat (20) @(negedge ref_clk_in);
        rstn_in = 1'b1;
        @(negedge ref_clk_in);
        por_in = 1'b1;
        @(negedge ref_clk_in);
        por_in = 1'b0;
        repeat (10) @(negedge ref_clk_in);
        t_word_erase();
        t_word_prog();
        t_block_prog();
        t_refused();
        t_good_cycle();
        t_abort();
        complete_run();
    end
    initial begin
        repeat (4000) @(posedge ref_clk_in);
        bad_count++;
        complete_run();
    end
endmodule // dee_tb_top
